// >>> inc/mac_pkg.sv
// Shared constants for the motor algorithm configuration and fault map
package mac_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_TUNING = 8'ha2;
    localparam logic [7:0] IDX_DRV_FAULT = 8'he0;
    localparam logic [7:0] IDX_CTL_FAULT = 8'he2;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;
    localparam logic [ADDR_W-1:0] ADDR_TUNING = {2'h0, IDX_TUNING, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DRV_FAULT = {2'h0, IDX_DRV_FAULT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTL_FAULT = {2'h0, IDX_CTL_FAULT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

    // Reset values
    localparam logic [31:0] TUNING_RST = 32'h0000_0000;
    localparam logic [31:0] FAULT_RST = 32'h0000_0000;
    localparam logic [1:0] IRQ_RST = 2'h0;

    // Tuning word field positions
    localparam int SLOW_ACC_LSB = 6;
    localparam int SLOW_ACC_W = 4;
    localparam int BRAKE_RAMP_LSB = 3;
    localparam int BRAKE_RAMP_W = 3;
    localparam int PD_SEL_BIT = 2;
    localparam int BEMF_SEL_BIT = 1;
    localparam int FINE_PD_BIT = 0;

    // Driver fault word: bit 31 summarises the flags in bits 30..0
    localparam int DRV_SUMMARY_BIT = 31;
    localparam int DRV_FLAG_W = 31;

    // Interrupt status bits
    localparam int IRQ_DRV_BIT = 0;
    localparam int IRQ_CTL_BIT = 1;
    localparam int IRQ_W = 2;

    // Slow acceleration in units of 0.1 Hz/s, by code
    localparam logic [15:0] ACCEL_TBL [16] = '{
        16'h0001, 16'h000a, 16'h0014, 16'h001e, 16'h0032, 16'h0064, 16'h00c8, 16'h012c,
        16'h0190, 16'h01f4, 16'h03e8, 16'h07d0, 16'h1388, 16'h1d4c, 16'h2710, 16'h4e20};

    // Brake current ramp in A/s, by code; the top code means no limit
    localparam logic [12:0] BRAKE_TBL [8] = '{
        13'h000a, 13'h0032, 13'h0064, 13'h00fa, 13'h01f4, 13'h03e8, 13'h1388, 13'h0000};
    localparam logic [2:0] BRAKE_NO_LIMIT = 3'h7;

    // Back-EMF references used with normal-run settings, percent
    localparam logic [6:0] BEMF_CURR_PCT = 7'h50;
    localparam logic [6:0] BEMF_SPEED_PCT = 7'h32;

endpackage

// >>> rtl/mac_decode.sv
// Decodes the tuning word into registered ramp values and parameter selections
`timescale 1ns/1ns
module mac_decode (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Stored tuning word
    input wire logic [31:0] tuning,
    // Candidate settings from the rest of the controller
    input wire logic [1:0] pulse_current_threshold,
    input wire logic [1:0] pulse_repeat_count,
    input wire logic [1:0] measure_pulse_current_cap,
    input wire logic [1:0] measure_pulse_repeat_count,
    input wire logic [2:0] measure_openloop_slew,
    input wire logic [2:0] measure_openloop_current,
    input wire logic [1:0] measure_openloop_speed,
    // Decoded results
    output logic [15:0] slow_accel_rate,
    output logic [12:0] brake_ramp_rate,
    output logic brake_ramp_unlimited,
    output logic [1:0] pd_current_sel,
    output logic [1:0] pd_repeat_sel,
    output logic bemf_use_openloop_coeff,
    output logic [2:0] bemf_slew_code,
    output logic [2:0] bemf_current_code,
    output logic [6:0] bemf_current_pct,
    output logic [1:0] bemf_speed_code,
    output logic [6:0] bemf_speed_pct,
    output logic fine_position_detect_enable
);

    // Field extraction
    wire logic [3:0] closed_loop_slow_accel = tuning[mac_pkg::SLOW_ACC_LSB +: mac_pkg::SLOW_ACC_W];
    wire logic [2:0] brake_current_ramp =
        tuning[mac_pkg::BRAKE_RAMP_LSB +: mac_pkg::BRAKE_RAMP_W];
    wire logic position_detect_param_select = tuning[mac_pkg::PD_SEL_BIT];
    wire logic bemf_measure_param_select = tuning[mac_pkg::BEMF_SEL_BIT];

    // Source selection
    wire logic [15:0] accel_nxt = mac_pkg::ACCEL_TBL[closed_loop_slow_accel]; // see [R1]
    wire logic [12:0] brake_nxt = mac_pkg::BRAKE_TBL[brake_current_ramp]; // see [R2]
    wire logic unlim_nxt = (brake_current_ramp == mac_pkg::BRAKE_NO_LIMIT); // see [R2]
    wire logic [1:0] pd_cur_nxt = position_detect_param_select ?
        measure_pulse_current_cap : pulse_current_threshold; // see [R3]
    wire logic [1:0] pd_rep_nxt = position_detect_param_select ?
        measure_pulse_repeat_count : pulse_repeat_count; // see [R3]
    wire logic [6:0] bemf_cpct_nxt = bemf_measure_param_select ? 7'h00 :
        mac_pkg::BEMF_CURR_PCT; // see [R4]
    wire logic [6:0] bemf_spct_nxt = bemf_measure_param_select ? 7'h00 :
        mac_pkg::BEMF_SPEED_PCT; // see [R4]

    // Registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_accel_rate <= 16'h0000;
            brake_ramp_rate <= 13'h0000;
            brake_ramp_unlimited <= 1'b0;
            pd_current_sel <= 2'h0;
            pd_repeat_sel <= 2'h0;
            bemf_use_openloop_coeff <= 1'b0;
            bemf_slew_code <= 3'h0;
            bemf_current_code <= 3'h0;
            bemf_current_pct <= 7'h00;
            bemf_speed_code <= 2'h0;
            bemf_speed_pct <= 7'h00;
            fine_position_detect_enable <= 1'b0;
        end else begin
            slow_accel_rate <= accel_nxt;
            brake_ramp_rate <= brake_nxt;
            brake_ramp_unlimited <= unlim_nxt;
            pd_current_sel <= pd_cur_nxt;
            pd_repeat_sel <= pd_rep_nxt;
            bemf_use_openloop_coeff <= ~bemf_measure_param_select; // see [R4]
            bemf_slew_code <= bemf_measure_param_select ? measure_openloop_slew : 3'h0;
            bemf_current_code <= bemf_measure_param_select ? measure_openloop_current : 3'h0;
            bemf_current_pct <= bemf_cpct_nxt;
            bemf_speed_code <= bemf_measure_param_select ? measure_openloop_speed : 2'h0;
            bemf_speed_pct <= bemf_spct_nxt;
            fine_position_detect_enable <= tuning[mac_pkg::FINE_PD_BIT]; // see [R5]
        end
    end

endmodule

// >>> rtl/mac_regs.sv
// APB register bank: algorithm tuning word, fault status words, fault interrupt
//
// Contract
// [R1] Four-bit slow closed-loop acceleration code selects ramp
// [R2] Three-bit brake current ramp; top code unlimited
// [R3] Selector picks position-detect current and repeat source
// [R4] Selector picks back-EMF measurement references or defaults
// [R5] Lowest tuning bit enables fine position detection
// [R6] Software leaves unlisted fault offsets untouched
// [R7] Read-only driver fault word, zero after reset
// [R8] Read-only controller fault word, zero after reset
// [R9] Driver word top bit ORs its fault flags
// [R10] Parity and reserved tuning bits stored unchanged
//
// The APB register port was decided locally.
`timescale 1ns/1ns
module mac_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mac_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Live fault flags from the power stage and the controller
    input wire logic [mac_pkg::DRV_FLAG_W-1:0] driver_fault_in,
    input wire logic [31:0] controller_fault_in,
    // Candidate settings from the rest of the controller
    input wire logic [1:0] pulse_current_threshold,
    input wire logic [1:0] pulse_repeat_count,
    input wire logic [1:0] measure_pulse_current_cap,
    input wire logic [1:0] measure_pulse_repeat_count,
    input wire logic [2:0] measure_openloop_slew,
    input wire logic [2:0] measure_openloop_current,
    input wire logic [1:0] measure_openloop_speed,
    // Decoded algorithm settings
    output logic [15:0] slow_accel_rate,
    output logic [12:0] brake_ramp_rate,
    output logic brake_ramp_unlimited,
    output logic [1:0] pd_current_sel,
    output logic [1:0] pd_repeat_sel,
    output logic bemf_use_openloop_coeff,
    output logic [2:0] bemf_slew_code,
    output logic [2:0] bemf_current_code,
    output logic [6:0] bemf_current_pct,
    output logic [1:0] bemf_speed_code,
    output logic [6:0] bemf_speed_pct,
    output logic fine_position_detect_enable,
    // Interrupt
    output logic fault_irq
);

    // Byte-lane merge used by every writable register
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Storage
    logic [31:0] algorithm_tuning_two_r;
    logic [31:0] driver_fault_flags_r;
    logic [31:0] controller_fault_flags_r;
    logic [mac_pkg::IRQ_W-1:0] irq_status_r;
    logic [mac_pkg::IRQ_W-1:0] irq_mask_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic fault_irq_r;

    // Address decode
    wire logic hit_tuning = (paddr == mac_pkg::ADDR_TUNING);
    wire logic hit_drv = (paddr == mac_pkg::ADDR_DRV_FAULT);
    wire logic hit_ctl = (paddr == mac_pkg::ADDR_CTL_FAULT);
    wire logic hit_irq_st = (paddr == mac_pkg::ADDR_IRQ_STATUS);
    wire logic hit_irq_mk = (paddr == mac_pkg::ADDR_IRQ_MASK);
    wire logic hit_any = hit_tuning | hit_drv | hit_ctl | hit_irq_st | hit_irq_mk;
    // Fault words are read-only; a write there is refused with an error
    wire logic bad_access = ~hit_any | (pwrite & (hit_drv | hit_ctl)); // see [R6]

    // Phase decode: setup cycle, and the access edge that completes a transfer
    wire logic setup_phase = psel & ~penable;
    wire logic access_done = psel & penable & pready_r;
    wire logic wr_done = access_done & pwrite & ~pslverr_r;
    wire logic wr_tuning = wr_done & hit_tuning;
    wire logic wr_irq_st = wr_done & hit_irq_st;
    wire logic wr_irq_mk = wr_done & hit_irq_mk;

    // Fault word composition
    wire logic drv_summary = |driver_fault_in; // see [R9]
    wire logic [31:0] drv_word_nxt = {drv_summary, driver_fault_in}; // see [R7] [R9]
    wire logic [31:0] ctl_word_nxt = controller_fault_in; // see [R8]

    // Events: a fault word goes from clear to non-zero
    wire logic drv_event = (drv_word_nxt != 32'h0000_0000) &
        (driver_fault_flags_r == 32'h0000_0000);
    wire logic ctl_event = (ctl_word_nxt != 32'h0000_0000) &
        (controller_fault_flags_r == 32'h0000_0000);
    wire logic [mac_pkg::IRQ_W-1:0] irq_set = {ctl_event, drv_event};
    // Lane-merged write data for the clear and mask registers
    wire logic [31:0] clr_lanes = merge_lanes(32'h0000_0000, pwdata, pstrb);
    wire logic [31:0] mask_lanes =
        merge_lanes({{(32-mac_pkg::IRQ_W){1'b0}}, irq_mask_r}, pwdata, pstrb);
    wire logic [mac_pkg::IRQ_W-1:0] irq_clr = wr_irq_st ?
        clr_lanes[mac_pkg::IRQ_W-1:0] : {mac_pkg::IRQ_W{1'b0}};
    // Set wins over a clear in the same cycle
    wire logic [mac_pkg::IRQ_W-1:0] irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;
    wire logic [mac_pkg::IRQ_W-1:0] irq_mask_nxt = wr_irq_mk ?
        mask_lanes[mac_pkg::IRQ_W-1:0] : irq_mask_r;

    // Tuning word: every bit, parity and reserved included, kept as written
    wire logic [31:0] tuning_nxt = wr_tuning ?
        merge_lanes(algorithm_tuning_two_r, pwdata, pstrb) :
        algorithm_tuning_two_r; // see [R10] [R1] [R2] [R3] [R4] [R5]

    // Read mux; unmapped locations read as zero
    wire logic [31:0] rd_mux =
        ({32{hit_tuning}} & algorithm_tuning_two_r) |
        ({32{hit_drv}} & driver_fault_flags_r) | // see [R7]
        ({32{hit_ctl}} & controller_fault_flags_r) | // see [R8]
        ({32{hit_irq_st}} & {{(32-mac_pkg::IRQ_W){1'b0}}, irq_status_r}) |
        ({32{hit_irq_mk}} & {{(32-mac_pkg::IRQ_W){1'b0}}, irq_mask_r});

    // Bus response: ready in the first access cycle, data latched at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup_phase;
            pslverr_r <= setup_phase & bad_access;
            prdata_r <= (setup_phase & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Tuning register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            algorithm_tuning_two_r <= mac_pkg::TUNING_RST;
        end else begin
            algorithm_tuning_two_r <= tuning_nxt;
        end
    end

    // Volatile fault words follow the live flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driver_fault_flags_r <= mac_pkg::FAULT_RST; // see [R7]
            controller_fault_flags_r <= mac_pkg::FAULT_RST; // see [R8]
        end else begin
            driver_fault_flags_r <= drv_word_nxt;
            controller_fault_flags_r <= ctl_word_nxt;
        end
    end

    // Interrupt status, mask and output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= mac_pkg::IRQ_RST;
            irq_mask_r <= mac_pkg::IRQ_RST;
            fault_irq_r <= 1'b0;
        end else begin
            irq_status_r <= irq_status_nxt;
            irq_mask_r <= irq_mask_nxt;
            fault_irq_r <= |(irq_status_nxt & irq_mask_nxt);
        end
    end

    // Bus outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign fault_irq = fault_irq_r;

    // Field decode and parameter selection
    mac_decode u_decode (
        .pclk(pclk),
        .presetn(presetn),
        .tuning(algorithm_tuning_two_r),
        .pulse_current_threshold(pulse_current_threshold),
        .pulse_repeat_count(pulse_repeat_count),
        .measure_pulse_current_cap(measure_pulse_current_cap),
        .measure_pulse_repeat_count(measure_pulse_repeat_count),
        .measure_openloop_slew(measure_openloop_slew),
        .measure_openloop_current(measure_openloop_current),
        .measure_openloop_speed(measure_openloop_speed),
        .slow_accel_rate(slow_accel_rate),
        .brake_ramp_rate(brake_ramp_rate),
        .brake_ramp_unlimited(brake_ramp_unlimited),
        .pd_current_sel(pd_current_sel),
        .pd_repeat_sel(pd_repeat_sel),
        .bemf_use_openloop_coeff(bemf_use_openloop_coeff),
        .bemf_slew_code(bemf_slew_code),
        .bemf_current_code(bemf_current_code),
        .bemf_current_pct(bemf_current_pct),
        .bemf_speed_code(bemf_speed_code),
        .bemf_speed_pct(bemf_speed_pct),
        .fine_position_detect_enable(fine_position_detect_enable)
    );

endmodule

// >>> sim/mac_regs_assertions.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module mac_regs_assertions (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mac_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Decoded settings
    input wire logic [15:0] slow_accel_rate,
    input wire logic brake_ramp_unlimited,
    input wire logic bemf_use_openloop_coeff,
    input wire logic fine_position_detect_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed transfer, and a completed low-lane write to the tuning word
    sequence acc_done;
        psel && penable && pready;
    endsequence
    sequence tune_wr;
        acc_done ##0 (pwrite && paddr == mac_pkg::ADDR_TUNING && pstrb[0]);
    endsequence
    AST_PREADY_ONE: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a one-cycle answer after setup");
    AST_PRDATA_IDLE: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
        else $error("prdata not zero outside a read access");
    AST_SLOW_TOP: assert property (
        tune_wr ##0 (pstrb[1] && pwdata[9:6] == 4'hf) |=> ##1 slow_accel_rate == 16'h4e20)
        else $error("top acceleration code gives wrong rate");
    AST_BRAKE_UNLIM: assert property (
        tune_wr |=> ##1 brake_ramp_unlimited == ($past(pwdata[5:3], 2) == 3'h7))
        else $error("brake unlimited flag wrong");
    AST_BEMF_SEL: assert property (
        tune_wr |=> ##1 bemf_use_openloop_coeff == !$past(pwdata[1], 2))
        else $error("back-emf coefficient selection wrong");
    AST_FINE_EN: assert property (
        tune_wr |=> ##1 fine_position_detect_enable == $past(pwdata[0], 2))
        else $error("fine position enable wrong");
    AST_DRV_SUMMARY: assert property (
        acc_done ##0 (!pwrite && paddr == mac_pkg::ADDR_DRV_FAULT)
        |-> prdata[31] == |prdata[30:0] && !pslverr)
        else $error("driver summary bit disagrees with flags");
    AST_FAULT_RO: assert property (
        acc_done ##0 (pwrite && (paddr == mac_pkg::ADDR_DRV_FAULT
        || paddr == mac_pkg::ADDR_CTL_FAULT)) |-> pslverr)
        else $error("write to fault word not refused");
endmodule

// >>> sim/test_mac_regs.sv
// Self-checking bench for the register bank
`timescale 1ns/1ns
module test_mac_regs;
    localparam logic [11:0] A_TUN = mac_pkg::ADDR_TUNING;
    localparam logic [11:0] A_DRV = mac_pkg::ADDR_DRV_FAULT;
    localparam logic [11:0] A_CTL = mac_pkg::ADDR_CTL_FAULT;
    localparam logic [11:0] A_STS = mac_pkg::ADDR_IRQ_STATUS;
    localparam logic [11:0] A_MSK = mac_pkg::ADDR_IRQ_MASK;
    // Design inputs, all given a value at time zero
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, controller_fault_in = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [30:0] driver_fault_in = 31'h0;
    logic [1:0] pulse_current_threshold = 2'h0, pulse_repeat_count = 2'h0;
    logic [1:0] measure_pulse_current_cap = 2'h0, measure_pulse_repeat_count = 2'h0;
    logic [2:0] measure_openloop_slew = 3'h0, measure_openloop_current = 3'h0;
    logic [1:0] measure_openloop_speed = 2'h0;
    // Design outputs
    logic [31:0] prdata;
    logic pready, pslverr, brake_ramp_unlimited, bemf_use_openloop_coeff;
    logic fine_position_detect_enable, fault_irq;
    logic [15:0] slow_accel_rate;
    logic [12:0] brake_ramp_rate;
    logic [1:0] pd_current_sel, pd_repeat_sel, bemf_speed_code;
    logic [2:0] bemf_slew_code, bemf_current_code;
    logic [6:0] bemf_current_pct, bemf_speed_pct;
    // Model state and expected rate tables
    int num_errors = 0;
    int checked = 0;
    int acc[16] = '{1, 10, 20, 30, 50, 100, 200, 300, 400, 500, 1000, 2000, 5000, 7500,
        10000, 20000};
    int brk[8] = '{10, 50, 100, 250, 500, 1000, 5000, 0};
    logic [11:0] ra[5] = '{A_TUN, A_DRV, A_CTL, A_STS, A_MSK};
    logic [31:0] tune, r, wv, df, cf;
    logic e;

    mac_regs dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .driver_fault_in(driver_fault_in),
        .controller_fault_in(controller_fault_in),
        .pulse_current_threshold(pulse_current_threshold),
        .pulse_repeat_count(pulse_repeat_count),
        .measure_pulse_current_cap(measure_pulse_current_cap),
        .measure_pulse_repeat_count(measure_pulse_repeat_count),
        .measure_openloop_slew(measure_openloop_slew),
        .measure_openloop_current(measure_openloop_current),
        .measure_openloop_speed(measure_openloop_speed),
        .slow_accel_rate(slow_accel_rate), .brake_ramp_rate(brake_ramp_rate),
        .brake_ramp_unlimited(brake_ramp_unlimited), .pd_current_sel(pd_current_sel),
        .pd_repeat_sel(pd_repeat_sel), .bemf_use_openloop_coeff(bemf_use_openloop_coeff),
        .bemf_slew_code(bemf_slew_code), .bemf_current_code(bemf_current_code),
        .bemf_current_pct(bemf_current_pct), .bemf_speed_code(bemf_speed_code),
        .bemf_speed_pct(bemf_speed_pct),
        .fine_position_detect_enable(fine_position_detect_enable), .fault_irq(fault_irq)
    );

    // 100 MHz clock
    initial begin
        forever #5 pclk = ~pclk;
    end

    // Compare and count
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; result left in r and e
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Verdict and end of run
    task automatic close_out();
        if (num_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #50000;
        num_errors++;
        close_out();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h4de32dbd));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Every mapped word reads zero after reset
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0, 4'h0);
            chk(r, 32'h0);
        end
        // Every acceleration and brake code, random selectors and settings
        for (int c = 0; c < 16; c++) begin
            wv = $urandom;
            wv[9:6] = c[3:0];
            wv[5:3] = c[2:0];
            {pulse_current_threshold, pulse_repeat_count, measure_pulse_current_cap,
                measure_pulse_repeat_count, measure_openloop_slew, measure_openloop_current,
                measure_openloop_speed} <= 16'($urandom);
            apb(1'b1, A_TUN, wv, 4'hf);
            tune = wv;
            chk(e, 1'b0);
            apb(1'b0, A_TUN, 32'h0, 4'h0);
            chk(r, tune);
            chk(slow_accel_rate, acc[c]);
            chk(brake_ramp_rate, brk[c % 8]);
            chk(brake_ramp_unlimited, c[2:0] == 3'h7);
            chk({pd_current_sel, pd_repeat_sel}, tune[2] ? {measure_pulse_current_cap,
                measure_pulse_repeat_count} : {pulse_current_threshold,
                pulse_repeat_count});
            chk({bemf_use_openloop_coeff, bemf_slew_code, bemf_current_code, bemf_speed_code,
                bemf_current_pct, bemf_speed_pct}, tune[1] ? {1'b0, measure_openloop_slew,
                measure_openloop_current, measure_openloop_speed, 14'h0}
                : {1'b1, 8'h0, 7'h50, 7'h32});
            chk(fine_position_detect_enable, tune[0]);
        end
        // Single byte lane write leaves the rest intact
        apb(1'b1, A_TUN, 32'hffffffff, 4'h2);
        tune[15:8] = 8'hff;
        apb(1'b0, A_TUN, 32'h0, 4'h0);
        chk(r, tune);
        // Driver faults: summary bit, masked event, then unmasked
        df = $urandom | 32'h1;
        driver_fault_in <= df[30:0];
        repeat (3) @(posedge pclk);
        apb(1'b0, A_DRV, 32'h0, 4'h0);
        chk(r, {1'b1, df[30:0]});
        apb(1'b0, A_STS, 32'h0, 4'h0);
        chk({r, fault_irq}, {32'h1, 1'b0});
        apb(1'b1, A_MSK, 32'h1, 4'hf);
        apb(1'b0, A_MSK, 32'h0, 4'h0);
        chk({r, fault_irq}, {32'h1, 1'b1});
        apb(1'b1, A_STS, 32'h1, 4'hf);
        apb(1'b0, A_STS, 32'h0, 4'h0);
        chk({r, fault_irq}, {32'h0, 1'b0});
        // Controller faults, refused writes to both fault words
        cf = $urandom | 32'h1;
        controller_fault_in <= cf;
        repeat (3) @(posedge pclk);
        apb(1'b1, A_CTL, ~cf, 4'hf);
        chk(e, 1'b1);
        apb(1'b1, A_DRV, 32'h0, 4'hf);
        chk(e, 1'b1);
        apb(1'b0, A_CTL, 32'h0, 4'h0);
        chk({r, e}, {cf, 1'b0});
        apb(1'b0, A_STS, 32'h0, 4'h0);
        chk({r, fault_irq}, {32'h2, 1'b0});
        apb(1'b1, A_MSK, 32'h3, 4'hf);
        apb(1'b0, A_MSK, 32'h0, 4'h0);
        chk({r, fault_irq}, {32'h3, 1'b1});
        driver_fault_in <= 31'h0;
        repeat (3) @(posedge pclk);
        apb(1'b0, A_DRV, 32'h0, 4'h0);
        chk(r, 32'h0);
        // Unmapped offset is refused both ways
        apb(1'b1, 12'h004, 32'hffffffff, 4'hf);
        chk(e, 1'b1);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        chk({r, e}, {32'h0, 1'b1});
        // Reset in mid-run clears outputs and registers
        presetn <= 1'b0;
        @(posedge pclk);
        chk({slow_accel_rate, fine_position_detect_enable, fault_irq}, 32'h0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_TUN, 32'h0, 4'h0);
        chk(r, 32'h0);
        apb(1'b0, A_MSK, 32'h0, 4'h0);
        chk(r, 32'h0);
        close_out();
    end
endmodule

bind mac_regs mac_regs_assertions chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_accel_rate(slow_accel_rate),
    .brake_ramp_unlimited(brake_ramp_unlimited),
    .bemf_use_openloop_coeff(bemf_use_openloop_coeff),
    .fine_position_detect_enable(fine_position_detect_enable)
);
